/* File: hbscp_pkg.sv */
package hbscp_pkg;

  // Timing
  localparam int unsigned CLK_SYS_MHZ        = 100;
  localparam int unsigned ACCESS_DELAY_US    = 2000;
  localparam int unsigned ACCESS_DELAY_CYCLES = ACCESS_DELAY_US * CLK_SYS_MHZ;
  localparam int unsigned DELAY_CNT_W        = 18;

  // Serial frame: direction bit, 8 address bits, 8 data bits, all MSB first
  localparam logic [4:0] SER_CNT_ADDR_DONE = 5'h09;
  localparam logic [4:0] SER_CNT_FRAME     = 5'h11;

  // Levels of the straps and the direction pin
  localparam logic STYLE_DATA_STROBE = 1'b0;
  localparam logic BUS_PARALLEL      = 1'b0;
  localparam logic DIR_READ          = 1'b1;

  // Reset values
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] SHIFT_RST = 16'h0000;

  typedef struct packed {
    logic       cs_n;
    logic [7:0] addr;
    logic [7:0] data;
    logic       dir_sdi;       // Direction, write strobe or serial data in
    logic       strobe;        // Data strobe, read strobe or serial clock
    logic       style;
    logic       serial;
  } hbscp_pins_t;

  typedef struct packed {
    logic rd;
    logic wr;
  } hbscp_strobes_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PAR_WAIT,
    ST_PAR_WR,
    ST_PAR_RD,
    ST_SER,
    ST_DONE
  } hbscp_state_t;

endpackage : hbscp_pkg

/* File: hbscp_sync.sv */
`timescale 1ns/1ns
module hbscp_sync
  import hbscp_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk_sys,  // System clock
  input  wire logic         i_reset_n,  // Synchronous reset, active low
  input  wire logic [W-1:0] i_d,        // Asynchronous inputs
  output logic      [W-1:0] o_q         // Synchronised outputs
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = i_d;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_q = sync_reg;

endmodule : hbscp_sync

/* File: hbscp_port.sv */
`timescale 1ns/1ns
module hbscp_port
  import hbscp_pkg::*;
#(
  parameter int unsigned P_ACCESS_DELAY = ACCESS_DELAY_CYCLES
) (
  input  wire logic       i_clk_sys,             // System clock, 100 MHz
  input  wire logic       i_reset_n,             // Synchronous reset, active low
  input  wire logic       i_cs_n,                // Chip select pin
  input  wire logic [7:0] i_addr,                // Parallel address pins
  input  wire logic [7:0] i_data,                // Data bus pin inputs
  input  wire logic       i_rw_wr_sdi,           // Direction / write strobe / serial in
  input  wire logic       i_data_strobe_n,       // Data strobe / read strobe / serial clock
  input  wire logic       i_strobe_style_strap,  // Parallel strobe style strap
  input  wire logic       i_serial_bus_select,   // Bus type strap
  input  wire logic       i_irq_pending,         // Any unmasked interrupt bit set
  input  wire logic [7:0] i_reg_rdata,           // Register read data, same cycle as read pulse
  output logic      [7:0] o_data,                // Data bus pin outputs
  output logic      [7:0] o_data_oe_n,           // Data bus enables, low drives
  output logic            o_int_n,               // Interrupt pin output level
  output logic            o_int_oe_n,            // Interrupt pin enable, low drives
  output logic      [7:0] o_reg_addr,            // Register address
  output logic      [7:0] o_reg_wdata,           // Register write data
  output logic            o_reg_wr,              // Register write pulse
  output logic            o_reg_rd,              // Register read pulse
  output logic            o_access_ready         // Access delay has elapsed
);

  function automatic hbscp_strobes_t decode_strobes(input logic style,
                                                    input logic dir,
                                                    input logic strobe);
    hbscp_strobes_t s;
    if (style == STYLE_DATA_STROBE) begin
      s.rd = !strobe && (dir == DIR_READ);
      s.wr = !strobe && (dir != DIR_READ);
    end else begin
      s.rd = !strobe;
      s.wr = !dir;
    end
    return s;
  endfunction : decode_strobes

  hbscp_pins_t    pins_raw;
  hbscp_pins_t    pins;
  hbscp_strobes_t par;

  assign pins_raw = '{cs_n: i_cs_n, addr: i_addr, data: i_data, dir_sdi: i_rw_wr_sdi,
                      strobe: i_data_strobe_n, style: i_strobe_style_strap,
                      serial: i_serial_bus_select};

  hbscp_sync #(
    .W ($bits(hbscp_pins_t))
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_d       (pins_raw),
    .o_q       (pins)
  );

  hbscp_state_t           state_reg,      state_next;
  logic                   seen_high_reg,  seen_high_next;
  logic                   style_reg,      style_next;
  logic                   serial_reg,     serial_next;
  logic                   sclk_prev_reg,  sclk_prev_next;
  logic [4:0]             cnt_reg,        cnt_next;
  logic [15:0]            sin_reg,        sin_next;
  logic [7:0]             sout_reg,       sout_next;
  logic                   sdo_reg,        sdo_next;
  logic                   ser_rd_reg,     ser_rd_next;
  logic                   load_reg,       load_next;
  logic [7:0]             addr_reg,       addr_next;
  logic [7:0]             wdata_reg,      wdata_next;
  logic [7:0]             rdata_reg,      rdata_next;
  logic                   wr_reg,         wr_next;
  logic                   rd_reg,         rd_next;
  logic                   int_reg,        int_next;
  logic [DELAY_CNT_W-1:0] delay_reg,      delay_next;
  logic                   ready_reg,      ready_next;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   ser_read;

  assign par       = decode_strobes(style_reg, pins.dir_sdi, pins.strobe);
  assign sclk_rise = pins.strobe && !sclk_prev_reg;
  assign sclk_fall = !pins.strobe && sclk_prev_reg;
  // Direction is latched: the shift register carries it away with every later bit
  assign ser_read  = ser_rd_reg;

  always_comb begin
    state_next     = state_reg;
    seen_high_next = seen_high_reg;
    style_next     = style_reg;
    serial_next    = serial_reg;
    sclk_prev_next = pins.strobe;
    cnt_next       = cnt_reg;
    sin_next       = sin_reg;
    sout_next      = sout_reg;
    sdo_next       = sdo_reg;
    ser_rd_next    = ser_rd_reg;
    load_next      = 1'b0;
    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    rdata_next     = rdata_reg;
    wr_next        = 1'b0;
    rd_next        = 1'b0;
    int_next       = i_irq_pending;
    delay_next     = delay_reg;
    ready_next     = ready_reg;

    // Accesses inside the settle time after reset are dropped
    if (!ready_reg) begin
      if (delay_reg == DELAY_CNT_W'(P_ACCESS_DELAY - 1)) begin
        ready_next = 1'b1;
      end else begin
        delay_next = delay_reg + DELAY_CNT_W'(1);
      end
    end

    if (load_reg) begin
      rdata_next = i_reg_rdata;
      sout_next  = i_reg_rdata;
    end

    if (pins.cs_n) begin
      // Partial serial frames and open parallel cycles are abandoned
      state_next     = ST_IDLE;
      seen_high_next = 1'b1;
      style_next     = pins.style;
      serial_next    = pins.serial;
      cnt_next       = 5'h00;
      ser_rd_next    = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Only a fresh falling select after a high one opens a cycle
          if (seen_high_reg && ready_reg) begin
            state_next = (serial_reg == BUS_PARALLEL) ? ST_PAR_WAIT : ST_SER;
          end else begin
            state_next = ST_DONE;
          end
        end
        ST_PAR_WAIT: begin
          if (par.rd) begin
            addr_next  = pins.addr;
            rd_next    = 1'b1;
            load_next  = 1'b1;
            state_next = ST_PAR_RD;
          end else if (par.wr) begin
            addr_next  = pins.addr;
            wdata_next = pins.data;
            state_next = ST_PAR_WR;
          end
        end
        ST_PAR_WR: begin
          // Data is taken at the trailing strobe edge, where it is settled
          if (par.wr) begin
            addr_next  = pins.addr;
            wdata_next = pins.data;
          end else begin
            wr_next    = 1'b1;
            state_next = ST_DONE;
          end
        end
        ST_PAR_RD: begin
          if (!par.rd) begin
            state_next = ST_DONE;
          end
        end
        ST_SER: begin
          if (sclk_rise) begin
            sin_next = {sin_reg[14:0], pins.dir_sdi};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == SER_CNT_ADDR_DONE - 5'h01 && sin_reg[7] == DIR_READ) begin
              addr_next = {sin_reg[6:0], pins.dir_sdi};
              ser_rd_next = 1'b1;
              rd_next   = 1'b1;
              load_next = 1'b1;
            end
            if (cnt_reg == SER_CNT_FRAME - 5'h01) begin
              state_next = ST_DONE;
              if (sin_reg[15] != DIR_READ) begin
                addr_next  = sin_reg[14:7];
                wdata_next = {sin_reg[6:0], pins.dir_sdi};
                wr_next    = 1'b1;
              end
            end
          end else if (sclk_fall && cnt_reg >= SER_CNT_ADDR_DONE && ser_read) begin
            sdo_next  = sout_reg[7];
            sout_next = {sout_reg[6:0], 1'b0};
          end
        end
        ST_DONE: begin
          state_next = ST_DONE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_reg     <= ST_IDLE;
      seen_high_reg <= 1'b0;
      style_reg     <= STYLE_DATA_STROBE;
      serial_reg    <= BUS_PARALLEL;
      sclk_prev_reg <= 1'b0;
      cnt_reg       <= 5'h00;
      sin_reg       <= SHIFT_RST;
      sout_reg      <= BYTE_RST;
      sdo_reg       <= 1'b0;
      ser_rd_reg    <= 1'b0;
      load_reg      <= 1'b0;
      addr_reg      <= BYTE_RST;
      wdata_reg     <= BYTE_RST;
      rdata_reg     <= BYTE_RST;
      wr_reg        <= 1'b0;
      rd_reg        <= 1'b0;
      int_reg       <= 1'b0;
      delay_reg     <= '0;
      ready_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      seen_high_reg <= seen_high_next;
      style_reg     <= style_next;
      serial_reg    <= serial_next;
      sclk_prev_reg <= sclk_prev_next;
      cnt_reg       <= cnt_next;
      sin_reg       <= sin_next;
      sout_reg      <= sout_next;
      sdo_reg       <= sdo_next;
      ser_rd_reg    <= ser_rd_next;
      load_reg      <= load_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      rdata_reg     <= rdata_next;
      wr_reg        <= wr_next;
      rd_reg        <= rd_next;
      int_reg       <= int_next;
      delay_reg     <= delay_next;
      ready_reg     <= ready_next;
    end
  end

  // Bus drive follows the synchronised strobe, so release lags the pin by 2-3 cycles
  always_comb begin
    o_data      = rdata_reg;
    o_data_oe_n = 8'hFF;
    if (!pins.cs_n && state_reg == ST_PAR_RD) begin
      o_data_oe_n = 8'h00;
    end else if (!pins.cs_n && state_reg == ST_SER && cnt_reg >= SER_CNT_ADDR_DONE
                 && ser_read) begin
      o_data      = {rdata_reg[7:1], sdo_reg};
      o_data_oe_n = 8'hFE;
    end
  end

  assign o_int_n        = 1'b0;
  assign o_int_oe_n     = !int_reg;
  assign o_reg_addr     = addr_reg;
  assign o_reg_wdata    = wdata_reg;
  assign o_reg_wr       = wr_reg;
  assign o_reg_rd       = rd_reg;
  assign o_access_ready = ready_reg;

endmodule : hbscp_port

/* File: hbscp_port_chk.sv */
`timescale 1ns/1ns
module hbscp_chk (
  input wire logic       i_clk_sys,            // System clock
  input wire logic       i_reset_n,            // Reset, active low
  input wire logic       i_cs_n,               // Chip select pin
  input wire logic       i_serial_bus_select,  // Bus type strap
  input wire logic       i_irq_pending,        // Pending interrupt
  input wire logic [7:0] o_data_oe_n,          // Data bus enables
  input wire logic       o_int_n,              // Interrupt level
  input wire logic       o_int_oe_n,           // Interrupt enable
  input wire logic       o_reg_wr,             // Write pulse
  input wire logic       o_reg_rd,             // Read pulse
  input wire logic       o_access_ready        // Delay elapsed
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // Four samples cover the two-flop pin synchroniser and the registered access pulse
  sequence s_cs_idle;
    i_cs_n [*4];
  endsequence
  sequence s_one_pulse;
    (o_reg_wr || o_reg_rd) ##1 !(o_reg_wr || o_reg_rd);
  endsequence
  chk_int_open_drain: assert property (i_irq_pending |=> !o_int_oe_n && o_int_n == 1'b0)
    else $error("interrupt line level not low");
  chk_int_pull_low: assert property (i_irq_pending |=> !o_int_oe_n)
    else $error("interrupt not pulled low");
  chk_int_release: assert property (!i_irq_pending |=> o_int_oe_n)
    else $error("interrupt not released");
  chk_cs_quiet: assert property (s_cs_idle |-> !o_reg_wr && !o_reg_rd)
    else $error("access while deselected");
  chk_cs_no_drive: assert property (s_cs_idle |-> o_data_oe_n == 8'hFF)
    else $error("bus driven while deselected");
  chk_pulse_single: assert property ((o_reg_wr || o_reg_rd) |-> s_one_pulse)
    else $error("access pulse too long");
  chk_ready_gate: assert property (!o_access_ready |-> !(o_reg_wr || o_reg_rd))
    else $error("access before ready");
  chk_ready_stays: assert property (o_access_ready |=> o_access_ready)
    else $error("ready dropped");
  chk_par_drive: assert property (o_reg_rd && !i_serial_bus_select |-> ##[1:3] o_data_oe_n == 8'h00)
    else $error("read data not driven");
  chk_ser_bit0_only: assert property (i_serial_bus_select |-> o_data_oe_n[7:1] == 7'h7F)
    else $error("serial mode drives upper bits");
endmodule : hbscp_chk

/* File: hbscp_host.sv */
`timescale 1ns/1ns
module hbscp_host
  import hbscp_pkg::*;
(
  input  wire logic       i_clk_sys,  // System clock
  input  wire logic [7:0] i_data,     // Resolved data bus level
  output hbscp_pins_t     o_pins,     // Host side of the pins
  output logic            o_drv       // Host drives the data bus
);
  initial begin
    o_pins = {1'b1, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0};
    o_drv  = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  // Straps move only while deselected, so no access ever sees them change
  task automatic par(input logic sty, input logic rd, input logic [7:0] a,
                     input logic [7:0] wd, input logic cs, output logic [7:0] rdv);
    o_pins.style   <= sty;
    o_pins.serial  <= 1'b0;
    o_pins.strobe  <= 1'b1;
    o_pins.dir_sdi <= sty | rd;
    cyc(4);
    o_pins.cs_n <= !cs;
    o_pins.addr <= a;
    o_pins.data <= wd;
    o_drv       <= !rd;
    cyc(3);
    if (sty && !rd) o_pins.dir_sdi <= 1'b0;
    else o_pins.strobe <= 1'b0;
    cyc(8);
    rdv = i_data;
    o_pins.strobe  <= 1'b1;
    o_pins.dir_sdi <= sty | rd;
    cyc(5);
    o_pins.cs_n <= 1'b1;
    o_drv       <= 1'b0;
    cyc(4);
  endtask : par
  // Serial clock stands low outside frames; style strap left untouched
  task automatic ser(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                     input int nbits, output logic [7:0] rdv);
    logic [16:0] f;
    f = {rd, a, wd};
    rdv = 8'h00;
    o_pins.serial <= 1'b1;
    o_pins.addr   <= 8'h00;
    o_pins.strobe <= 1'b0;
    cyc(4);
    o_pins.cs_n <= 1'b0;
    cyc(4);
    for (int i = 0; i < nbits; i++) begin
      o_pins.dir_sdi <= f[16 - i];
      cyc(4);
      if (i > 8) rdv = {rdv[6:0], i_data[0]};
      o_pins.strobe <= 1'b1;
      cyc(4);
      o_pins.strobe <= 1'b0;
    end
    cyc(6);
    o_pins.cs_n <= 1'b1;
    cyc(4);
  endtask : ser
endmodule : hbscp_host

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import hbscp_pkg::*;
  localparam int unsigned P_DELAY = 20;
  logic        i_clk_sys  = 1'b0;
  logic        i_reset_n  = 1'b0;
  logic        irq        = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  tog        = 8'h00;
  logic [7:0]  mem [256];
  logic [7:0]  model [256];
  wire  [7:0]  d_wire;
  hbscp_pins_t pins;
  logic        drv;
  logic [7:0]  o_data, oe_n, reg_addr, reg_wdata, got, a, wd;
  logic        int_n, int_oe_n, reg_wr, reg_rd, ready, sty;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  // Released lines flip every cycle so a stale value can never pass
  for (genvar b = 0; b < 8; b++) begin : g_bus
    assign d_wire[b] = !oe_n[b] ? o_data[b] : (drv ? pins.data[b] : tog[b]);
  end
  hbscp_port #(.P_ACCESS_DELAY(P_DELAY)) dut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cs_n(pins.cs_n), .i_addr(pins.addr),
    .i_data(d_wire), .i_rw_wr_sdi(pins.dir_sdi), .i_data_strobe_n(pins.strobe),
    .i_strobe_style_strap(pins.style), .i_serial_bus_select(pins.serial),
    .i_irq_pending(irq), .i_reg_rdata(rdata), .o_data(o_data), .o_data_oe_n(oe_n),
    .o_int_n(int_n), .o_int_oe_n(int_oe_n), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_access_ready(ready));
  hbscp_host host (.i_clk_sys(i_clk_sys), .i_data(d_wire), .o_pins(pins), .o_drv(drv));
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  function automatic logic [7:0] expect_rd(input logic [7:0] ad);
    return model[ad];
  endfunction : expect_rd
  // Register core stand-in; the port takes read data at the end of the read pulse's cycle
  assign rdata = mem[reg_addr];
  always @(posedge i_clk_sys) begin
    tog <= ~tog;
    irq <= 1'(($urandom % 8) < 3);
    if (reg_wr) mem[reg_addr] <= reg_wdata;
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(33617));
    repeat (12) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (P_DELAY - 2) @(posedge i_clk_sys);
    #1;
    check({7'h00, ready}, 8'h00);
    repeat (5) @(posedge i_clk_sys);
    #1;
    check({7'h00, ready}, 8'h01);
    $display("test ready delay done");
    for (int it = 0; it < 6; it++) begin
      a   = 8'($urandom);
      wd  = 8'($urandom);
      sty = 1'($urandom);
      if (it == 0) {a, wd, sty} = {8'hFF, 8'h00, 1'b0};
      if (it == 1) {a, wd, sty} = {8'h00, 8'hFF, 1'b1};
      host.par(sty, 1'b0, a, wd, 1'b1, got);
      model[a] = wd;
      host.par(!sty, 1'b1, a, 8'h00, 1'b1, got);
      check(got, expect_rd(a));
      host.par(sty, 1'b0, a, ~wd, 1'b0, got);
      host.ser(1'b1, a, 8'h00, 17, got);
      check(got, expect_rd(a));
      host.ser(1'b0, a ^ 8'h01, ~wd, 17, got);
      model[a ^ 8'h01] = ~wd;
      host.ser(1'b0, a ^ 8'h01, wd, 12, got);
      host.par(sty, 1'b1, a ^ 8'h01, 8'h00, 1'b1, got);
      check(got, expect_rd(a ^ 8'h01));
      $display("test round %0d done", it);
    end
    complete_run();
  end
endmodule : tb_top
bind hbscp_port hbscp_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
  .i_serial_bus_select(i_serial_bus_select), .i_irq_pending(i_irq_pending),
  .o_data_oe_n(o_data_oe_n), .o_int_n(o_int_n), .o_int_oe_n(o_int_oe_n),
  .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd), .o_access_ready(o_access_ready));
